/* File: rtl/cfa_config_access.sv */
/*
 Configuration address/data window, configuration target decode and forwarding, the base
 address register of the memory-mapped region, row width and drive-strength selection.
 Assumes host I/O and memory cycles arrive as one-cycle strobes synchronous to mclk, and that
 forwarded cycles complete by a one-cycle done strobe from the hub or graphics side.
*/
`timescale 1ns/1ps
`include "cfa_map.svh"
// Summary of operation
// - Device number drives hub/graphics bits 15:11
// - Function number drives bits 10:8
// - Ignore own-function access with nonzero function
// - Register number drives bits 7:2
// - Data window at 0CFCh, 32 bits, zero reset
// - Window follows current address register contents
// - Data access becomes config only when enabled
// - Region base register at config offset 14h
// - Base register hidden after reset, reads zero
// - Decode 2Ch row width, 30h-34h strengths
// - Row width 8 bits, reset 00h, upper reserved
// - Row bit 1 means 8-bit devices
// - Rows 0-1 set clocks 2:0, rows 2-3 clocks 5:3
// - No config access while enable bit clear
// - Bus 0, device 0 or 1 claimed locally
// - Secondary bus type 0, subordinate range type 1
// - Row width picks x8 or x16 strength
module cfa_config_access (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [15:0] ioAddr,
    input wire logic [31:0] ioWrData,
    output logic [31:0] ioRdData,
    output logic ioDone,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [31:0] memAddr,
    input wire logic [3:0] memByteEn,
    input wire logic [31:0] memWrData,
    output logic [31:0] memRdData,
    output logic memDone,
    input wire logic barUnhide,
    input wire logic [7:0] secondaryBus,
    input wire logic [7:0] subordinateBus,
    output logic hubCfgReq,
    output logic [15:0] hubCfgAddr,
    output logic gfxCfgReq,
    output logic gfxCfgType1,
    output logic [31:0] graphicsAddrDataLine,
    output logic fwdWrite,
    output logic [31:0] fwdWrData,
    input wire logic fwdDone,
    input wire logic [31:0] fwdRdData,
    output logic [7:0] dramRowWidth,
    output logic [5:0] clockPairX8,
    output logic [2:0] ckeStrength,
    output logic [2:0] csStrength,
    output logic [2:0] ckStrength
);
    //--------------------------------------------------------------
    // Decode helpers
    //--------------------------------------------------------------
    function automatic cfa_pkg::cfa_target_t decodeTarget(input logic [31:0] a, input logic [7:0] sec,
                                                        input logic [7:0] sub);
        logic [7:0] bus;
        bus = a[`CFA_BUS_HI:`CFA_BUS_LO];
        if (!a[`CFA_ADDR_ENABLE_BIT]) begin
            decodeTarget = cfa_pkg::CFA_TGT_NONE;
        end else if (bus == 8'h00 && a[`CFA_DEV_HI:`CFA_DEV_LO] < 5'h02) begin
            decodeTarget = cfa_pkg::CFA_TGT_LOCAL;
        end else if (bus != 8'h00 && bus >= sec && bus <= sub) begin
            decodeTarget = cfa_pkg::CFA_TGT_GFX;
        end else begin
            decodeTarget = cfa_pkg::CFA_TGT_HUB;
        end
    endfunction : decodeTarget

    // Picks x8 strength when any row on the group is x8 wide
    function automatic logic [2:0] pickStrength(input logic [7:0] s, input logic anyX8);
        pickStrength = anyX8 ? s[2:0] : s[6:4];
    endfunction : pickStrength

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    cfa_pkg::cfa_state_t st_r, st_nxt;
    logic [31:0] cfgAddr_r, cfgAddr_nxt;
    logic [31:0] cfgData_r, cfgData_nxt;
    logic [31:0] bar_r, bar_nxt;
    logic [7:0] rowWidth_r, rowWidth_nxt;
    logic [31:0] ioRdData_nxt, memRdData_nxt;
    logic ioDone_nxt, memDone_nxt;
    logic hubReq_nxt, gfxReq_nxt, gfxT1_nxt, fwdWrite_nxt;
    logic [15:0] hubAddr_nxt;
    logic [31:0] gfxAd_nxt, fwdWrData_nxt;
    logic [5:0] clkX8_nxt;
    logic [2:0] cke_nxt, cs_nxt, ck_nxt;
    cfa_pkg::cfa_target_t tgt;
    logic inRegion, strWr;
    logic [11:0] mmOff;
    logic [7:0] strRd;
    logic [39:0] strAll;
    logic [7:0] busField;

    assign tgt = decodeTarget(cfgAddr_r, secondaryBus, subordinateBus);
    assign busField = cfgAddr_r[`CFA_BUS_HI:`CFA_BUS_LO];
    // Region is 4 KB; a zero base never matches
    assign inRegion = (bar_r != 32'h00000000) && (memAddr[31:12] == bar_r[31:12]);
    assign mmOff = memAddr[11:0];
    assign strWr = memWrite && inRegion && mmOff[11:2] == `CFA_MM_STR_FIRST >> 2 && memByteEn != 4'h0;

    //--------------------------------------------------------------
    // Drive-strength storage
    //--------------------------------------------------------------
    // Strength 30h-33h share one dword; byte lane zero of 34h dword handled below
    logic [2:0] strWrIdx;
    logic [7:0] strWrByte;
    logic strWrEn;
    always_comb begin
        strWrIdx = 3'h0;
        strWrByte = memWrData[7:0];
        strWrEn = 1'b0;
        if (memWrite && inRegion && mmOff[11:2] == `CFA_MM_STR_LAST >> 2 && memByteEn[0]) begin
            strWrIdx = 3'h4;
            strWrEn = 1'b1;
        end else if (strWr) begin
            // Single-lane write is the only legal form; lowest enabled lane wins
            strWrEn = 1'b1;
            if (memByteEn[0]) begin
                strWrIdx = 3'h0;
                strWrByte = memWrData[7:0];
            end else if (memByteEn[1]) begin
                strWrIdx = 3'h1;
                strWrByte = memWrData[15:8];
            end else if (memByteEn[2]) begin
                strWrIdx = 3'h2;
                strWrByte = memWrData[23:16];
            end else begin
                strWrIdx = 3'h3;
                strWrByte = memWrData[31:24];
            end
        end
    end

    cfa_strength_bank u_strength (
        .mclk(mclk),
        .nrst(nrst),
        .wrEn(strWrEn),
        .wrIdx(strWrIdx),
        .wrData(strWrByte),
        .rdIdx(3'h0),
        .rdData(strRd),
        .allStrength(strAll)
    );

    //--------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        cfgAddr_nxt = cfgAddr_r;
        cfgData_nxt = cfgData_r;
        bar_nxt = bar_r;
        rowWidth_nxt = rowWidth_r;
        ioRdData_nxt = ioRdData;
        ioDone_nxt = 1'b0;
        memRdData_nxt = 32'h00000000;
        memDone_nxt = 1'b0;
        hubReq_nxt = hubCfgReq;
        gfxReq_nxt = gfxCfgReq;
        gfxT1_nxt = gfxCfgType1;
        hubAddr_nxt = hubCfgAddr;
        gfxAd_nxt = graphicsAddrDataLine;
        fwdWrite_nxt = fwdWrite;
        fwdWrData_nxt = fwdWrData;
        case (st_r)
            cfa_pkg::CFA_ST_IDLE: begin
                if ((ioWrite || ioRead) && ioAddr == `CFA_IO_ADDR_SEL) begin
                    if (ioWrite) begin
                        cfgAddr_nxt = ioWrData & `CFA_ADDR_RW_MASK;
                    end
                    ioRdData_nxt = cfgAddr_r;
                    ioDone_nxt = 1'b1;
                end else if ((ioWrite || ioRead) && ioAddr == `CFA_IO_DATA_WIN) begin
                    ioDone_nxt = 1'b1;
                    ioRdData_nxt = cfgData_r;
                    if (ioWrite) begin
                        cfgData_nxt = ioWrData;
                    end
                    case (tgt)
                        cfa_pkg::CFA_TGT_LOCAL: begin
                            // Only function 0 of the hub bridge exists here
                            if (cfgAddr_r[`CFA_FUNC_HI:`CFA_FUNC_LO] == 3'h0 &&
                                cfgAddr_r[`CFA_DEV_HI:`CFA_DEV_LO] == 5'h00 &&
                                cfgAddr_r[`CFA_REG_HI:`CFA_REG_LO] == `CFA_CFG_BAR_OFFSET) begin
                                ioRdData_nxt = barUnhide ? bar_r : 32'h00000000;
                                if (ioWrite && barUnhide) begin
                                    bar_nxt = ioWrData & `CFA_BAR_MASK;
                                end
                            end else begin
                                ioRdData_nxt = 32'h00000000;
                            end
                        end
                        cfa_pkg::CFA_TGT_GFX, cfa_pkg::CFA_TGT_HUB: begin
                            ioDone_nxt = 1'b0;
                            st_nxt = cfa_pkg::CFA_ST_FWD;
                            fwdWrite_nxt = ioWrite;
                            fwdWrData_nxt = ioWrData;
                            if (tgt == cfa_pkg::CFA_TGT_GFX) begin
                                gfxReq_nxt = 1'b1;
                                gfxT1_nxt = busField != secondaryBus;
                                gfxAd_nxt = {16'h0000, cfgAddr_r[15:2], 2'b00};
                            end else begin
                                hubReq_nxt = 1'b1;
                                hubAddr_nxt = {cfgAddr_r[15:2], 2'b00};
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            cfa_pkg::CFA_ST_FWD: begin
                if (fwdDone) begin
                    hubReq_nxt = 1'b0;
                    gfxReq_nxt = 1'b0;
                    ioRdData_nxt = fwdRdData;
                    if (!fwdWrite) begin
                        cfgData_nxt = fwdRdData;
                    end
                    ioDone_nxt = 1'b1;
                    st_nxt = cfa_pkg::CFA_ST_IDLE;
                end
            end
            default: begin
                st_nxt = cfa_pkg::CFA_ST_IDLE;
            end
        endcase
        // Memory-mapped region; other offsets read zero
        if ((memRead || memWrite) && inRegion) begin
            memDone_nxt = 1'b1;
            if (mmOff[11:2] == `CFA_MM_ROW_WIDTH >> 2) begin
                // Row width is lane zero; lanes 1-3 of this dword are reserved
                memRdData_nxt = {24'h000000, rowWidth_r};
                if (memWrite && memByteEn[0]) begin
                    rowWidth_nxt = memWrData[7:0] & `CFA_ROW_WIDTH_MASK;
                end
            end else if (mmOff[11:2] == `CFA_MM_STR_FIRST >> 2) begin
                memRdData_nxt = strAll[31:0];
            end else if (mmOff[11:2] == `CFA_MM_STR_LAST >> 2) begin
                memRdData_nxt = {24'h000000, strAll[39:32]};
            end
        end
        // Rows 0-1 to pairs 2:0, rows 2-3 to pairs 5:3
        clkX8_nxt = {{3{|rowWidth_r[3:2]}}, {3{|rowWidth_r[1:0]}}};
        cke_nxt = pickStrength(strAll[15:8], |rowWidth_r[3:0]);
        cs_nxt = pickStrength(strAll[23:16], |rowWidth_r[3:0]);
        ck_nxt = pickStrength(strAll[31:24], |rowWidth_r[3:0]);
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= cfa_pkg::CFA_ST_IDLE;
            cfgAddr_r <= 32'h00000000;
            cfgData_r <= `CFA_DATA_RESET;
            bar_r <= 32'h00000000;
            rowWidth_r <= `CFA_ROW_WIDTH_RESET;
            ioRdData <= 32'h00000000;
            ioDone <= 1'b0;
            memRdData <= 32'h00000000;
            memDone <= 1'b0;
            hubCfgReq <= 1'b0;
            hubCfgAddr <= 16'h0000;
            gfxCfgReq <= 1'b0;
            gfxCfgType1 <= 1'b0;
            graphicsAddrDataLine <= 32'h00000000;
            fwdWrite <= 1'b0;
            fwdWrData <= 32'h00000000;
            dramRowWidth <= `CFA_ROW_WIDTH_RESET;
            clockPairX8 <= 6'h00;
            ckeStrength <= 3'h0;
            csStrength <= 3'h0;
            ckStrength <= 3'h0;
        end else begin
            st_r <= st_nxt;
            cfgAddr_r <= cfgAddr_nxt;
            cfgData_r <= cfgData_nxt;
            bar_r <= bar_nxt;
            rowWidth_r <= rowWidth_nxt;
            ioRdData <= ioRdData_nxt;
            ioDone <= ioDone_nxt;
            memRdData <= memRdData_nxt;
            memDone <= memDone_nxt;
            hubCfgReq <= hubReq_nxt;
            hubCfgAddr <= hubAddr_nxt;
            gfxCfgReq <= gfxReq_nxt;
            gfxCfgType1 <= gfxT1_nxt;
            graphicsAddrDataLine <= gfxAd_nxt;
            fwdWrite <= fwdWrite_nxt;
            fwdWrData <= fwdWrData_nxt;
            dramRowWidth <= rowWidth_nxt;
            clockPairX8 <= clkX8_nxt;
            ckeStrength <= cke_nxt;
            csStrength <= cs_nxt;
            ckStrength <= ck_nxt;
        end
    end
endmodule : cfa_config_access

/* File: rtl/cfa_map.svh */
/*
 Offsets, field positions, reset values and decode constants for the configuration access block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CFA_MAP_SVH
`define CFA_MAP_SVH
`define CFA_IO_ADDR_SEL 16'h0CF8
`define CFA_IO_DATA_WIN 16'h0CFC
`define CFA_ADDR_ENABLE_BIT 31
`define CFA_BUS_HI 23
`define CFA_BUS_LO 16
`define CFA_DEV_HI 15
`define CFA_DEV_LO 11
`define CFA_FUNC_HI 10
`define CFA_FUNC_LO 8
`define CFA_REG_HI 7
`define CFA_REG_LO 2
`define CFA_ADDR_RW_MASK 32'h80FFFFFC
`define CFA_DATA_RESET 32'h00000000
`define CFA_CFG_BAR_OFFSET 6'h05
`define CFA_BAR_MASK 32'hFFFFF000
`define CFA_MM_ROW_WIDTH 12'h02C
`define CFA_MM_STR_FIRST 12'h030
`define CFA_MM_STR_LAST 12'h034
`define CFA_ROW_WIDTH_RESET 8'h00
`define CFA_ROW_WIDTH_MASK 8'h0F
`define CFA_STR_RESET 8'h00
`define CFA_STR_MASK 8'h77
`endif

/* File: rtl/cfa_pkg.sv */
/*
 Types shared by the configuration access block.
 Assumes cfa_map.svh supplies the numeric constants.
*/
package cfa_pkg;
    typedef enum logic [1:0] {
        CFA_TGT_NONE,
        CFA_TGT_LOCAL,
        CFA_TGT_GFX,
        CFA_TGT_HUB
    } cfa_target_t;
    typedef enum logic [1:0] {
        CFA_ST_IDLE,
        CFA_ST_FWD,
        CFA_ST_DONE
    } cfa_state_t;
endpackage : cfa_pkg

/* File: rtl/cfa_strength_bank.sv */
/*
 Five byte-wide drive-strength registers with a registered read port.
 Assumes the caller decodes the memory-mapped region and gives a byte index 0 to 4.
*/
`timescale 1ns/1ps
`include "cfa_map.svh"
module cfa_strength_bank (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [7:0] wrData,
    input wire logic [2:0] rdIdx,
    output logic [7:0] rdData,
    output logic [39:0] allStrength
);
    logic [7:0] mem_r [0:4];
    logic [7:0] mem_nxt [0:4];
    logic [7:0] rdData_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_byte
            always_comb begin
                mem_nxt[gi] = mem_r[gi];
                if (wrEn && wrIdx == 3'(gi)) begin
                    mem_nxt[gi] = wrData & `CFA_STR_MASK;
                end
            end
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    mem_r[gi] <= `CFA_STR_RESET;
                end else begin
                    mem_r[gi] <= mem_nxt[gi];
                end
            end
            assign allStrength[gi*8 +: 8] = mem_r[gi];
        end
    endgenerate
    always_comb begin
        rdData_nxt = (rdIdx < 3'h5) ? mem_r[rdIdx] : 8'h00;
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= rdData_nxt;
        end
    end
endmodule : cfa_strength_bank

/* File: tb/cfa_config_access_props.sv */
/* Port-level assertions for cfa_config_access.
   Assumes binding to the design top; sees only its ports. */
`timescale 1ns/1ps
module cfa_config_access_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ioRead,
    input wire logic ioWrite,
    input wire logic ioDone,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic memDone,
    input wire logic hubCfgReq,
    input wire logic [15:0] hubCfgAddr,
    input wire logic gfxCfgReq,
    input wire logic fwdDone,
    input wire logic [7:0] dramRowWidth,
    input wire logic [5:0] clockPairX8
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // ----------------
    // Relations
    // ----------------
    AST_IO_CAUSE: assert property (ioDone |-> $past(ioRead || ioWrite || fwdDone))
        else $error("ioDone without cause");
    AST_MEM_CAUSE: assert property (memDone |-> $past(memRead || memWrite))
        else $error("memDone without cause");
    AST_REQ_EXCL: assert property (!(hubCfgReq && gfxCfgReq))
        else $error("two targets at once");
    AST_REQ_HOLD: assert property (hubCfgReq && !fwdDone |=> hubCfgReq && $stable(hubCfgAddr))
        else $error("hub request moved early");
    AST_DONE_FWD: assert property ((hubCfgReq || gfxCfgReq) && fwdDone |=> ioDone && !hubCfgReq && !gfxCfgReq)
        else $error("forward end not answered");
    AST_HUB_LOW: assert property (hubCfgReq |-> hubCfgAddr[1:0] == 2'h0)
        else $error("low address bits forwarded");
    AST_ROW_RSVD: assert property (dramRowWidth[7:4] == 4'h0)
        else $error("row width reserved bits set");
    // Pairs follow row width one cycle late
    AST_CLK_PAIR: assert property (1'b1 |=> clockPairX8 == {{3{|$past(dramRowWidth[3:2])}}, {3{|$past(dramRowWidth[1:0])}}})
        else $error("clock pair loading wrong");
endmodule : cfa_config_access_props
bind cfa_config_access cfa_config_access_props u_props (.mclk, .nrst, .ioRead, .ioWrite, .ioDone, .memRead,
    .memWrite, .memDone, .hubCfgReq, .hubCfgAddr, .gfxCfgReq, .fwdDone, .dramRowWidth, .clockPairX8);

/* File: tb/cfa_config_access_tb.sv */
/* Self-checking bench for cfa_config_access with a forward responder.
   Assumes a 50 MHz clock and single-dword host accesses. */
`timescale 1ns/1ps
module cfa_config_access_tb;
    localparam logic [31:0] BASE = 32'hFED40000;
    localparam logic [31:0] BUSES = 32'h09060400;
    logic mclk, nrst, ioWrite, ioRead, memWrite, memRead, barUnhide, ioDone, memDone;
    logic hubCfgReq, gfxCfgReq, gfxCfgType1, fwdWrite, fwdDone;
    logic [15:0] ioAddr, hubCfgAddr;
    logic [31:0] ioWrData, ioRdData, memAddr, memWrData, memRdData, graphicsAddrDataLine, fwdWrData, fwdRdData;
    logic [31:0] lastWrData, a, v;
    logic [7:0] secondaryBus, subordinateBus, dramRowWidth, w, bus;
    logic [5:0] clockPairX8;
    logic [3:0] memByteEn, lag;
    logic [2:0] ckeStrength, csStrength, ckStrength;
    logic [1:0] lastKind;
    logic [32:0] ex;
    logic [32:0] expQ[$];
    int reqCount, errTotal, compares, n;
    cfa_config_access dut (.mclk, .nrst, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioRdData, .ioDone, .memWrite,
        .memRead, .memAddr, .memByteEn, .memWrData, .memRdData, .memDone, .barUnhide, .secondaryBus,
        .subordinateBus, .hubCfgReq, .hubCfgAddr, .gfxCfgReq, .gfxCfgType1, .graphicsAddrDataLine, .fwdWrite,
        .fwdWrData, .fwdDone, .fwdRdData, .dramRowWidth, .clockPairX8, .ckeStrength, .csStrength, .ckStrength);
    cfa_fwd_model partner (.mclk, .hubCfgReq, .hubCfgAddr, .gfxCfgReq, .gfxCfgType1, .graphicsAddrDataLine,
        .fwdWrite, .fwdWrData, .lag, .fwdDone, .fwdRdData, .lastKind, .lastWrData, .reqCount);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ----------------
    // Checks and ending
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        compares++;
        if (seen !== expd) begin
            errTotal++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check
    task automatic close_out;
        $display("compares=%0d errors=%0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    always @(posedge mclk) begin
        if (nrst && (ioDone || memDone)) begin
            if (expQ.size() == 0) begin
                check(32'h0, 32'h1);
            end else begin
                ex = expQ.pop_front();
                if (ex[32]) check(ioDone ? ioRdData : memRdData, ex[31:0]);
            end
        end
    end
    // Single aligned dword or byte-lane access only
    task automatic op(input logic isIo, input logic wr, input logic [31:0] ad, input logic [3:0] be,
                      input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge mclk);
        #1;
        {ioWrite, ioRead, memWrite, memRead} = {isIo & wr, isIo & !wr, !isIo & wr, !isIo & !wr};
        ioAddr = ad[15:0];
        memAddr = BASE + ad;
        memByteEn = be;
        ioWrData = d;
        memWrData = d;
        expQ.push_back(e);
        @(posedge mclk);
        #1;
        {ioWrite, ioRead, memWrite, memRead} = 4'h0;
        for (k = 0; k < 40 && (isIo ? ioDone : memDone) !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        if (k == 40) begin
            errTotal++;
            close_out();
        end
    endtask : op
    // ----------------
    // Sequence
    // ----------------
    initial begin
        n = $urandom(32'h50bdb592);
        {ioWrite, ioRead, memWrite, memRead, barUnhide, lag, ioAddr, ioWrData, memAddr, memByteEn, memWrData} = '0;
        {errTotal, compares, nrst} = '0;
        secondaryBus = 8'h04;
        subordinateBus = 8'h08;
        repeat (5) @(posedge mclk);
        #1;
        nrst = 1'b1;
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, 32'h0});
        op(1, 1, 32'h0CF8, 4'hF, 32'hFFFFFFFF, 33'h0);
        op(1, 0, 32'h0CF8, 4'hF, 32'h0, {1'b1, 32'h80FFFFFC});
        for (n = 0; n < 8; n++) begin
            bus = BUSES[8 * (n % 4) +: 8];
            a = {8'h80, bus, 5'(2 + $urandom % 30), 11'($urandom)};
            lag = (n < 4) ? 4'h0 : 4'($urandom % 8);
            op(1, 1, 32'h0CF8, 4'hF, a, 33'h0);
            op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, 16'hC35A, a[15:2], 2'b00});
            check({30'h0, lastKind}, (bus == 8'h00 || bus == 8'h09) ? 32'h0 : {30'h1, bus == 8'h06});
        end
        v = $urandom;
        op(1, 1, 32'h0CFC, 4'hF, v, 33'h0);
        check(lastWrData, v);
        op(1, 1, 32'h0CF8, 4'hF, a & 32'h7FFFFFFF, 33'h0);
        n = reqCount;
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, v});
        op(1, 1, 32'h0CF8, 4'hF, 32'h80000114, 33'h0);
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, 32'h0});
        op(1, 1, 32'h0CF8, 4'hF, 32'h80000810, 33'h0);
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, 32'h0});
        check(reqCount, n);
        // Hidden base register, then visible
        op(1, 1, 32'h0CF8, 4'hF, 32'h80000014, 33'h0);
        op(1, 1, 32'h0CFC, 4'hF, BASE | 32'hABC, 33'h0);
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, 32'h0});
        @(posedge mclk);
        #1;
        barUnhide = 1'b1;
        op(1, 1, 32'h0CFC, 4'hF, BASE | 32'hABC, 33'h0);
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, BASE});
        op(0, 1, 32'h030, 4'h2, 32'h00003500, 33'h0);
        op(0, 1, 32'h030, 4'h4, 32'h00620000, 33'h0);
        op(0, 1, 32'h030, 4'h8, 32'h17000000, 33'h0);
        op(0, 0, 32'h030, 4'hF, 32'h0, {1'b1, 32'h17623500});
        op(0, 1, 32'h034, 4'h1, 32'h000000FF, 33'h0);
        op(0, 0, 32'h034, 4'hF, 32'h0, {1'b1, 32'h00000077});
        for (n = 0; n < 5; n++) begin
            w = (n == 0) ? 8'hF0 : 8'($urandom);
            op(0, 1, 32'h02C, 4'h1, {24'h0, w}, 33'h0);
            op(0, 1, 32'h02C, 4'hE, 32'hFFFFFF00, 33'h0);
            op(0, 0, 32'h02C, 4'hF, 32'h0, {1'b1, 24'h0, w & 8'h0F});
            repeat (2) @(posedge mclk);
            #1;
            check({26'h0, clockPairX8}, {26'h0, {3{|w[3:2]}}, {3{|w[1:0]}}});
            check({23'h0, ckeStrength, csStrength, ckStrength}, (|w[3:0]) ? 32'h157 : 32'h0F1);
        end
        op(0, 1, 32'h040, 4'hF, 32'hFFFFFFFF, 33'h0);
        op(0, 0, 32'h040, 4'hF, 32'h0, {1'b1, 32'h0});
        @(posedge mclk);
        #1;
        memRead = 1'b1;
        memAddr = BASE + 32'h1000;
        @(posedge mclk);
        #1;
        memRead = 1'b0;
        repeat (3) @(posedge mclk) check({31'h0, memDone}, 32'h0);
        #1;
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check({24'h0, dramRowWidth}, 32'h0);
        nrst = 1'b1;
        op(1, 0, 32'h0CFC, 4'hF, 32'h0, {1'b1, 32'h0});
        repeat (2) @(posedge mclk);
        check(expQ.size(), 32'h0);
        close_out();
    end
endmodule : cfa_config_access_tb

/* File: tb/cfa_fwd_model.sv */
/* Responder for forwarded hub and graphics configuration cycles.
   Assumes requests are levels held until the done pulse. */
`timescale 1ns/1ps
module cfa_fwd_model (
    input wire logic mclk,
    input wire logic hubCfgReq,
    input wire logic [15:0] hubCfgAddr,
    input wire logic gfxCfgReq,
    input wire logic gfxCfgType1,
    input wire logic [31:0] graphicsAddrDataLine,
    input wire logic fwdWrite,
    input wire logic [31:0] fwdWrData,
    input wire logic [3:0] lag,
    output logic fwdDone,
    output logic [31:0] fwdRdData,
    output logic [1:0] lastKind,
    output logic [31:0] lastWrData,
    output int reqCount
);
    initial begin
        {fwdDone, fwdRdData, lastKind, lastWrData} = '0;
        reqCount = 0;
        forever begin
            @(posedge mclk);
            #1;
            fwdDone = 1'b0;
            // Data toggles off the done cycle so stale reads show
            fwdRdData = ~fwdRdData;
            if (hubCfgReq || gfxCfgReq) begin
                reqCount++;
                lastKind = {gfxCfgReq, gfxCfgReq & gfxCfgType1};
                lastWrData = fwdWrite ? fwdWrData : lastWrData;
                repeat (lag) @(posedge mclk);
                #1;
                fwdDone = 1'b1;
                fwdRdData = {16'hC35A, gfxCfgReq ? graphicsAddrDataLine[15:0] : hubCfgAddr};
            end
        end
    end
endmodule : cfa_fwd_model
